// *** src/fpra_top.sv ***
`include "fpra_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module fpra_top
    import fpra_pkg::*;
#(
    parameter int unsigned SEC_CYCLES = `FPRA_SEC_NS / `FPRA_CLK_PERIOD_NS
) (
    input wire logic ref_clk_i, // 125 MHz clock.
    input wire logic rst_i, // Asynchronous reset, active high.
    input wire fpra_bus_req_t bus_i, // Register port request.
    output logic [31:0] rdata_o, // Read data, one cycle after read strobe.
    input wire fpra_tap_sense_t tap_i, // Tap-water temperature and validity.
    input wire logic normal_pump_i, // Normal tap-water pump demand.
    input wire logic pump_off_req_i, // Another subsystem wants the pump off.
    input wire logic other_burner_i, // Some other source demands the burner.
    input wire fpra_limit_req_t limit_i, // Rate limit requests and rates.
    input wire logic [7:0] mod_rate_i, // Modulation firing rate.
    input wire logic safety_lockout_i, // Safety limit demanding lockout.
    input wire logic safety_recycle_i, // Safety limit demanding recycle.
    output logic tap_pump_o, // Tap-water pump request.
    output logic frost_burner_o, // Frost burner demand.
    output logic frost_min_rate_o, // Frost demand asks for minimum rate.
    output logic [7:0] firing_rate_o, // Arbitrated firing rate.
    output logic alert_o, // Pulse when an abnormal limit engages.
    output logic lockout_o, // Burner lockout, sticky.
    output logic recycle_o // Burner recycle, follows its input one cycle later.
);

    // ==========================================================
    // Register port.

    logic [31:0] ctrl_q;
    logic [31:0] ovr_time_q;
    logic [31:0] limits_q;
    logic [3:0] alert_sts_q;
    logic [3:0] alert_sts_d;
    logic [31:0] rdata_d;
    logic [31:0] status_w;

    // Write decode by address.
    wire wr_ctrl = bus_i.we && (bus_i.addr == `FPRA_ADDR_CTRL);
    wire wr_ovr = bus_i.we && (bus_i.addr == `FPRA_ADDR_OVERRUN);
    wire wr_lim = bus_i.we && (bus_i.addr == `FPRA_ADDR_LIMITS);
    wire wr_alert = bus_i.we && (bus_i.addr == `FPRA_ADDR_ALERT);

    // Control fields.
    wire frost_en = ctrl_q[`FPRA_CTRL_FROST_EN];
    wire method_mid = ctrl_q[`FPRA_CTRL_METHOD];
    wire ovr_en = ctrl_q[`FPRA_CTRL_OVR_EN];
    wire [7:0] ovr_rate = ctrl_q[`FPRA_CTRL_OVR_LSB +: 8];
    wire lock_clr = wr_ctrl && bus_i.wdata[`FPRA_CTRL_LOCK_CLR];
    wire [5:0] lim_en = limits_q[5:0];
    wire [4:0] anti_wins = limits_q[`FPRA_LIM_PRIO_LSB +: 5];

    // Reads of unmapped addresses return zero; the lock clear bit reads zero.
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (bus_i.addr == `FPRA_ADDR_CTRL) begin
            rdata_d = ctrl_q;
        end else if (bus_i.addr == `FPRA_ADDR_OVERRUN) begin
            rdata_d = ovr_time_q;
        end else if (bus_i.addr == `FPRA_ADDR_LIMITS) begin
            rdata_d = limits_q;
        end else if (bus_i.addr == `FPRA_ADDR_STATUS) begin
            rdata_d = status_w;
        end else if (bus_i.addr == `FPRA_ADDR_ALERT) begin
            rdata_d = {28'h000_0000, alert_sts_q};
        end
    end

    // Configuration registers.
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_q <= `FPRA_CTRL_RST;
            ovr_time_q <= `FPRA_OVR_RST;
            limits_q <= `FPRA_LIM_RST;
            rdata_o <= 32'h0000_0000;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= {16'h0000, bus_i.wdata[15:8], 5'h00, bus_i.wdata[2:0]};
            end
            if (wr_ovr) begin
                ovr_time_q <= {11'h000, bus_i.wdata[20:16], 2'h0, bus_i.wdata[13:8],
                               2'h0, bus_i.wdata[5:0]};
            end
            if (wr_lim) begin
                limits_q <= {19'h0_0000, bus_i.wdata[12:8], 2'h0, bus_i.wdata[5:0]};
            end
            rdata_o <= bus_i.re ? rdata_d : 32'h0000_0000;
        end
    end

    // ==========================================================
    // Seconds timebase shared by the overrun and periodic burner timers.

    logic [31:0] sec_cnt_q;
    wire sec_tick = (sec_cnt_q == SEC_CYCLES - 1);

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sec_cnt_q <= 32'h0000_0000;
        end else begin
            sec_cnt_q <= sec_tick ? 32'h0000_0000 : sec_cnt_q + 32'h0000_0001;
        end
    end

    // ==========================================================
    // Tap-water temperature comparisons. The switch-source flag is not looked
    // at: frost protection always reads the sensor, only its validity matters.

    wire signed [11:0] t_pump_on = `FPRA_T_PUMP_ON;
    wire signed [11:0] t_end = `FPRA_T_FROST_END;
    wire signed [11:0] t_burn = `FPRA_T_BURN_ON;
    wire below_pump = tap_i.valid && (tap_i.temp < t_pump_on);
    wire above_end = tap_i.valid && (tap_i.temp > t_end);
    wire below_burn = tap_i.valid && (tap_i.temp < t_burn);

    // ==========================================================
    // Frost pump sequencer with overrun timer.

    fpra_pump_st_t pump_st_q;
    fpra_pump_st_t pump_st_d;
    logic [16:0] ovr_cnt_q;
    logic [16:0] ovr_cnt_d;

    // Overrun length in seconds; the widest setting fits in 17 bits.
    wire [16:0] ovr_load = 17'(ovr_time_q[`FPRA_OVR_HH_LSB +: 5] * `FPRA_SEC_PER_HOUR)
        + 17'(ovr_time_q[`FPRA_OVR_MM_LSB +: 6] * `FPRA_SEC_PER_MIN)
        + 17'(ovr_time_q[`FPRA_OVR_SS_LSB +: 6]);

    always_comb begin
        pump_st_d = pump_st_q;
        ovr_cnt_d = ovr_cnt_q;
        unique case (pump_st_q)
            FPRA_ST_IDLE: begin
                if (frost_en && below_pump) begin
                    pump_st_d = FPRA_ST_FROST;
                end
            end
            FPRA_ST_FROST: begin
                if (!frost_en) begin
                    pump_st_d = FPRA_ST_IDLE;
                end else if (above_end) begin
                    pump_st_d = FPRA_ST_OVERRUN;
                    ovr_cnt_d = ovr_load;
                end
            end
            FPRA_ST_OVERRUN: begin
                if (!frost_en) begin
                    pump_st_d = FPRA_ST_IDLE;
                end else if (below_pump) begin
                    pump_st_d = FPRA_ST_FROST;
                end else if (ovr_cnt_q == 17'h0_0000) begin
                    pump_st_d = FPRA_ST_IDLE;
                end else if (sec_tick) begin
                    ovr_cnt_d = ovr_cnt_q - 17'h0_0001;
                end
            end
            default: begin
                pump_st_d = FPRA_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pump_st_q <= FPRA_ST_IDLE;
            ovr_cnt_q <= 17'h0_0000;
        end else begin
            pump_st_q <= pump_st_d;
            ovr_cnt_q <= ovr_cnt_d;
        end
    end

    // Frost and overrun demand cannot be vetoed by an off request.
    wire frost_pump = (pump_st_q != FPRA_ST_IDLE);
    assign tap_pump_o = frost_pump || (normal_pump_i && !pump_off_req_i);

    // ==========================================================
    // Frost burner demand with continuous or periodic duty.

    logic burn_q;
    logic [11:0] phase_q;
    localparam logic [11:0] BURST_ON_S = 12'(`FPRA_BURST_ON_MIN * `FPRA_SEC_PER_MIN);
    localparam logic [11:0] BURST_LAST_S =
        12'((`FPRA_BURST_ON_MIN + `FPRA_BURST_OFF_MIN) * `FPRA_SEC_PER_MIN - 1);

    // Another source taking over ends the frost demand; it restarts only when
    // the conditions meet again, so the burst phase starts fresh each time.
    wire burn_start = frost_en && below_burn && !other_burner_i;
    wire burn_stop = !frost_en || above_end || other_burner_i;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            burn_q <= 1'b0;
            phase_q <= 12'h000;
        end else begin
            if (!burn_q) begin
                burn_q <= burn_start;
                phase_q <= 12'h000;
            end else if (burn_stop) begin
                burn_q <= 1'b0;
            end else if (sec_tick) begin
                phase_q <= (phase_q == BURST_LAST_S) ? 12'h000 : phase_q + 12'h001;
            end
        end
    end

    wire burst_on = !method_mid || (phase_q < BURST_ON_S);
    assign frost_burner_o = burn_q && burst_on && !other_burner_i;
    assign frost_min_rate_o = frost_burner_o && !method_mid;

    // ==========================================================
    // Rate limit arbitration.

    logic [7:0] pick_rate;
    logic [7:0] rate_q;
    logic pick_any;
    wire [5:0] lim_act = lim_en & limit_i.req;
    wire anti_act = lim_act[`FPRA_LIM_ANTI];
    wire [4:0] red_act = lim_act[4:0];
    // With anticondensation active only reducers that outrank it compete.
    wire [4:0] red_use = anti_act ? (red_act & ~anti_wins) : red_act;

    always_comb begin
        pick_rate = 8'hFF;
        pick_any = 1'b0;
        for (int i = 0; i < 5; i++) begin
            if (red_use[i] && (!pick_any || limit_i.rate[i] < pick_rate)) begin
                pick_rate = limit_i.rate[i];
                pick_any = 1'b1;
            end
        end
    end

    wire [7:0] limited_rate = pick_any ? pick_rate
        : (anti_act ? limit_i.rate[`FPRA_LIM_ANTI] : mod_rate_i);
    wire [7:0] rate_d = ovr_en ? ovr_rate : limited_rate;

    // ==========================================================
    // Alerts for abnormal limits, and safety lockout or recycle.

    logic [5:0] lim_act_q;
    wire [5:0] abn_rise = lim_act & ~lim_act_q & `FPRA_ABNORMAL_MASK;
    wire [3:0] abn_bits = {abn_rise[`FPRA_LIM_ANTI], abn_rise[`FPRA_LIM_OUTLET],
                           abn_rise[`FPRA_LIM_STACK], abn_rise[`FPRA_LIM_DELTA]};
    // Write one to clear; a new event in the same cycle keeps its bit.
    assign alert_sts_d = abn_bits | (alert_sts_q & ~(wr_alert ? bus_i.wdata[3:0] : 4'h0));

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rate_q <= 8'h00;
            lim_act_q <= 6'h00;
            alert_sts_q <= 4'h0;
            alert_o <= 1'b0;
            lockout_o <= 1'b0;
            recycle_o <= 1'b0;
        end else begin
            rate_q <= rate_d;
            lim_act_q <= lim_act;
            alert_sts_q <= alert_sts_d;
            alert_o <= |abn_bits;
            lockout_o <= safety_lockout_i || (lockout_o && !lock_clr);
            recycle_o <= safety_recycle_i;
        end
    end

    assign firing_rate_o = rate_q;
    assign status_w = {14'h0000, lim_act_q, burn_q, frost_pump, pump_st_q, rate_q};

    // ==========================================================
    // Checks.

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);

    a_pump_cold_start: assert property (
        (pump_st_q == FPRA_ST_IDLE) && frost_en && below_pump |=> tap_pump_o)
        else $error("Pump not requested below the on threshold.");

    a_pump_hold_frost: assert property (
        (pump_st_q == FPRA_ST_FROST) && frost_en && !above_end
        |=> (pump_st_q == FPRA_ST_FROST))
        else $error("Frost pump state left before exceeding the end threshold.");

    a_overrun_load_val: assert property (
        (pump_st_q == FPRA_ST_FROST) && frost_en && above_end
        |=> (pump_st_q == FPRA_ST_OVERRUN) && (ovr_cnt_q == $past(ovr_load)))
        else $error("Overrun timer not loaded from its setting.");

    a_pump_priority_hold: assert property (
        frost_pump && pump_off_req_i |-> tap_pump_o)
        else $error("Frost pump demand was overridden.");

    a_burner_min_rate: assert property (
        !burn_q && burn_start && !method_mid ##1 !other_burner_i && !method_mid
        |-> frost_burner_o && frost_min_rate_o)
        else $error("Frost burner demand missing below the burner threshold.");

    a_burner_lowest_prio: assert property (
        other_burner_i |-> !frost_burner_o ##1 !burn_q)
        else $error("Frost burner demand held against another source.");

    a_invalid_sensor_ignored: assert property (
        (pump_st_q == FPRA_ST_IDLE) && !tap_i.valid && !burn_q |=> !frost_pump && !burn_q)
        else $error("Invalid sensor reading acted upon.");

    a_cont_method_steady: assert property (
        burn_q && !method_mid && !burn_stop
        |=> burn_q && (frost_burner_o || other_burner_i) [*1])
        else $error("Continuous frost burner demand interrupted.");

    a_mid_method_off: assert property (
        burn_q && method_mid && (phase_q >= BURST_ON_S) |-> !frost_burner_o)
        else $error("Periodic frost burner on during its off phase.");

    a_override_forces_rate: assert property (
        ovr_en |=> firing_rate_o == $past(ovr_rate))
        else $error("Override rate not applied.");

    a_lockout_sticky: assert property (
        lockout_o && !lock_clr |=> lockout_o)
        else $error("Lockout released without a clear.");

    a_anti_alone_rate: assert property (
        !ovr_en && anti_act && (red_act == 5'h00)
        |=> firing_rate_o == $past(limit_i.rate[`FPRA_LIM_ANTI]))
        else $error("Anticondensation alone did not set the rate.");

    a_reducer_cap_rate: assert property (
        !ovr_en && !anti_act && red_act[`FPRA_LIM_SLOW]
        |=> firing_rate_o <= $past(limit_i.rate[`FPRA_LIM_SLOW]))
        else $error("Rate above an active reducer request.");

    a_alert_on_abnormal: assert property (
        $rose(lim_act[`FPRA_LIM_STACK]) |=> alert_o)
        else $error("No alert for an abnormal limit.");

    a_no_alert_normal: assert property (
        $rose(lim_act[`FPRA_LIM_SLOW]) && ((lim_act & ~lim_act_q & `FPRA_ABNORMAL_MASK) == 6'h00)
        |=> !alert_o)
        else $error("Alert raised for a normal limit.");

endmodule

`default_nettype wire

// *** include/fpra_defines.svh ***
`ifndef FPRA_DEFINES_SVH
`define FPRA_DEFINES_SVH

// ==========================================================
// Register map, word-aligned byte addresses.
`define FPRA_ADDR_CTRL 8'h00
`define FPRA_ADDR_OVERRUN 8'h04
`define FPRA_ADDR_LIMITS 8'h08
`define FPRA_ADDR_STATUS 8'h0C
`define FPRA_ADDR_ALERT 8'h10

// ==========================================================
// Control register fields.
`define FPRA_CTRL_FROST_EN 0
`define FPRA_CTRL_METHOD 1
`define FPRA_CTRL_OVR_EN 2
`define FPRA_CTRL_LOCK_CLR 3
`define FPRA_CTRL_OVR_LSB 8
`define FPRA_CTRL_RST 32'h0000_0000

// Overrun time fields, hours:minutes:seconds.
`define FPRA_OVR_SS_LSB 0
`define FPRA_OVR_MM_LSB 8
`define FPRA_OVR_HH_LSB 16
`define FPRA_OVR_RST 32'h0000_0000

// Limit enables in bits 5:0, anticondensation-wins bits from 8 upward.
`define FPRA_LIM_PRIO_LSB 8
`define FPRA_LIM_RST 32'h0000_0000

// ==========================================================
// Limit indices; the abnormal set is delta-T, stack, outlet and anticondensation.
`define FPRA_LIM_DELTA 0
`define FPRA_LIM_STACK 1
`define FPRA_LIM_SLOW 2
`define FPRA_LIM_OUTLET 3
`define FPRA_LIM_FORCED 4
`define FPRA_LIM_ANTI 5
`define FPRA_ABNORMAL_MASK 6'h2B

// ==========================================================
// Temperatures in whole degrees F, two's complement.
`define FPRA_T_PUMP_ON 12'h02D
`define FPRA_T_FROST_END 12'h032
`define FPRA_T_BURN_ON 12'h026

// ==========================================================
// Timing figures.
`define FPRA_SEC_NS 1000000000
`define FPRA_CLK_PERIOD_NS 8
`define FPRA_SEC_PER_MIN 60
`define FPRA_SEC_PER_HOUR 3600
`define FPRA_BURST_ON_MIN 5
`define FPRA_BURST_OFF_MIN 55

`endif

// *** include/fpra_pkg.sv ***
package fpra_pkg;

    // Frost pump sequencer states.
    typedef enum logic [1:0] {
        FPRA_ST_IDLE = 2'b00,
        FPRA_ST_FROST = 2'b01,
        FPRA_ST_OVERRUN = 2'b10
    } fpra_pump_st_t;

    // Tap-water sensor reading with its validity flag.
    typedef struct packed {
        logic signed [11:0] temp;
        logic valid;
        logic src_is_switch;
    } fpra_tap_sense_t;

    // Requests and rates of the six rate limits, indexed as in the defines.
    typedef struct packed {
        logic [5:0] req;
        logic [5:0][7:0] rate;
    } fpra_limit_req_t;

    // Plain register port request.
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic we;
        logic re;
    } fpra_bus_req_t;

endpackage

// *** dv/fpra_tap_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Tap-water sensor stand-in, registered like a real sampling front end.
module fpra_tap_model
    import fpra_pkg::*;
(
    input wire logic ref_clk_i, // Clock shared with the block.
    input wire logic rst_i, // Asynchronous reset, active high.
    input wire logic signed [11:0] temp_i, // Temperature the sensor should read.
    input wire logic ok_i, // Sensor is connected.
    input wire logic switch_i, // Demand source is set to a switch.
    output wire fpra_tap_sense_t tap_o // Reading as the block sees it.
);
    fpra_tap_sense_t rd_q = '0;

    // A disconnected sensor floats, so its reading flips every cycle rather than holding.
    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_q <= '0;
        end else begin
            rd_q.temp <= ok_i ? temp_i : ~rd_q.temp;
            rd_q.valid <= ok_i;
            rd_q.src_is_switch <= switch_i;
        end
    end

    // The reading leaves the model unchanged.
    assign tap_o = rd_q;
endmodule

`default_nettype wire

// *** dv/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "fpra_defines.svh"
`define FPRA_CHK(g, e) chk(32'(g), 32'(e))

// ==========================================================
// Self-checking bench for the frost sequencer and rate arbiter.
module tb import fpra_pkg::*;;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    fpra_bus_req_t bus = '0;
    fpra_tap_sense_t tap;
    fpra_limit_req_t lim = '0;
    logic signed [11:0] temp_set = 12'h046;
    logic ok = 1'b1;
    logic sw = 1'b0;
    logic normal_pump = 1'b0;
    logic pump_off = 1'b0;
    logic other_burner = 1'b0;
    logic lock_in = 1'b0;
    logic recyc_in = 1'b0;
    logic [7:0] mod_rate = 8'h40;
    logic [31:0] rdata_o;
    logic tap_pump_o, frost_burner_o, frost_min_rate_o, alert_o, lockout_o, recycle_o;
    logic [7:0] firing_rate_o;
    int n_mismatch = 0;
    int n_compared = 0;
    logic [7:0] addrs [5] = '{`FPRA_ADDR_CTRL, `FPRA_ADDR_OVERRUN, `FPRA_ADDR_LIMITS,
                              `FPRA_ADDR_ALERT, 8'h14};
    localparam logic [5:0] ABN = 6'h2B;

    // Free-running 125 MHz clock.
    always #4 ref_clk_i = ~ref_clk_i;

    fpra_tap_model sensor (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .temp_i(temp_set),
        .ok_i(ok), .switch_i(sw), .tap_o(tap));

    // One second is shortened to ten cycles so the hour-long burner cycle fits the run.
    fpra_top #(.SEC_CYCLES(10)) dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .bus_i(bus),
        .rdata_o(rdata_o), .tap_i(tap), .normal_pump_i(normal_pump),
        .pump_off_req_i(pump_off), .other_burner_i(other_burner), .limit_i(lim),
        .mod_rate_i(mod_rate), .safety_lockout_i(lock_in), .safety_recycle_i(recyc_in),
        .tap_pump_o(tap_pump_o), .frost_burner_o(frost_burner_o),
        .frost_min_rate_o(frost_min_rate_o), .firing_rate_o(firing_rate_o),
        .alert_o(alert_o), .lockout_o(lockout_o), .recycle_o(recycle_o));

    // ==========================================================
    // Comparison, timing and bus helpers.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask

    task automatic set_temp(input logic [11:0] t);
        @(posedge ref_clk_i);
        temp_set <= t;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        bus <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
        @(posedge ref_clk_i);
        bus <= '0;
    endtask

    // Read data stand for one cycle only, so both that cycle and the next are checked.
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk_i);
        bus <= '{addr: a, wdata: 32'h0000_0000, we: 1'b0, re: 1'b1};
        @(posedge ref_clk_i);
        bus <= '0;
        #1;
        `FPRA_CHK(rdata_o, exp);
        wait_cyc(1);
        `FPRA_CHK(rdata_o, 32'h0000_0000);
    endtask

    // Override first, then the reducers that outrank anticondensation, then it, then modulation.
    function automatic logic [7:0] exp_rate(input logic [5:0] en, input logic [4:0] wins,
        input fpra_limit_req_t l, input logic ovr, input logic [7:0] orate, input logic [7:0] mr);
        logic [5:0] act;
        logic [4:0] comp;
        logic [7:0] best;
        logic any;
        act = en & l.req;
        comp = act[4:0] & (act[5] ? ~wins : 5'h1F);
        best = 8'hFF;
        any = 1'b0;
        for (int i = 0; i < 5; i++) begin
            if (comp[i] && (!any || l.rate[i] < best)) begin
                best = l.rate[i];
                any = 1'b1;
            end
        end
        if (ovr) return orate;
        if (any) return best;
        if (act[5]) return l.rate[5];
        return mr;
    endfunction

    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ==========================================================
    // Main sequence.
    initial begin
        int cnt;
        logic [5:0] en;
        logic [4:0] wins;
        logic ovr;
        logic [7:0] orate;
        fpra_limit_req_t nl;
        void'($urandom(93));
        repeat (5) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        foreach (addrs[i]) rd(addrs[i], 32'h0000_0000);
        rd(`FPRA_ADDR_STATUS, 32'h0000_0040);
        wr(8'h14, 32'hFFFF_FFFF);
        rd(8'h14, 32'h0000_0000);
        $display("test regs done");
        // Cold water with a switch demand source and another subsystem wanting the pump off.
        wr(`FPRA_ADDR_CTRL, 32'h0000_0001);
        wr(`FPRA_ADDR_OVERRUN, 32'h0000_0003);
        @(posedge ref_clk_i);
        sw <= 1'b1;
        pump_off <= 1'b1;
        temp_set <= 12'h02D;
        wait_cyc(5);
        `FPRA_CHK(tap_pump_o, 1'b0);
        set_temp(12'h02C);
        wait_cyc(4);
        `FPRA_CHK(tap_pump_o, 1'b1);
        `FPRA_CHK(frost_burner_o, 1'b0);
        set_temp(12'h026);
        wait_cyc(4);
        `FPRA_CHK(frost_burner_o, 1'b0);
        set_temp(12'h025);
        wait_cyc(4);
        `FPRA_CHK(frost_burner_o, 1'b1);
        `FPRA_CHK(frost_min_rate_o, 1'b1);
        wait_cyc(200);
        `FPRA_CHK(frost_burner_o, 1'b1);
        @(posedge ref_clk_i);
        other_burner <= 1'b1;
        wait_cyc(3);
        `FPRA_CHK(frost_burner_o, 1'b0);
        @(posedge ref_clk_i);
        other_burner <= 1'b0;
        temp_set <= 12'h032;
        wait_cyc(5);
        `FPRA_CHK(tap_pump_o, 1'b1);
        @(posedge ref_clk_i);
        pump_off <= 1'b0;
        temp_set <= 12'h033;
        wait_cyc(15);
        `FPRA_CHK(tap_pump_o, 1'b1);
        `FPRA_CHK(frost_burner_o, 1'b0);
        wait_cyc(40);
        `FPRA_CHK(tap_pump_o, 1'b0);
        @(posedge ref_clk_i);
        normal_pump <= 1'b1;
        wait_cyc(2);
        `FPRA_CHK(tap_pump_o, 1'b1);
        @(posedge ref_clk_i);
        normal_pump <= 1'b0;
        ok <= 1'b0;
        temp_set <= 12'h025;
        wait_cyc(20);
        `FPRA_CHK(tap_pump_o, 1'b0);
        `FPRA_CHK(frost_burner_o, 1'b0);
        $display("test frost done");
        // Periodic method: five minutes on, fifty-five off, at 600 cycles a minute.
        wr(`FPRA_ADDR_CTRL, 32'h0000_0003);
        @(posedge ref_clk_i);
        ok <= 1'b1;
        wait_cyc(4);
        `FPRA_CHK(frost_burner_o, 1'b1);
        `FPRA_CHK(frost_min_rate_o, 1'b0);
        wait_cyc(2970);
        `FPRA_CHK(frost_burner_o, 1'b1);
        wait_cyc(40);
        `FPRA_CHK(frost_burner_o, 1'b0);
        wait_cyc(32960);
        `FPRA_CHK(frost_burner_o, 1'b0);
        wait_cyc(40);
        `FPRA_CHK(frost_burner_o, 1'b1);
        set_temp(12'h046);
        wr(`FPRA_ADDR_CTRL, 32'h0000_0000);
        $display("test periodic done");
        // Safety lockout is sticky until cleared; recycle follows its input.
        @(posedge ref_clk_i);
        lock_in <= 1'b1;
        recyc_in <= 1'b1;
        wait_cyc(3);
        `FPRA_CHK(lockout_o, 1'b1);
        `FPRA_CHK(recycle_o, 1'b1);
        @(posedge ref_clk_i);
        lock_in <= 1'b0;
        recyc_in <= 1'b0;
        wait_cyc(3);
        `FPRA_CHK(lockout_o, 1'b1);
        `FPRA_CHK(recycle_o, 1'b0);
        wr(`FPRA_ADDR_CTRL, 32'h0000_0008);
        wait_cyc(2);
        `FPRA_CHK(lockout_o, 1'b0);
        $display("test safety done");
        // Random arbitration with fixed corners: all reducers outranked, anti alone, no limit.
        for (int k = 0; k < 150; k++) begin
            en = 6'($urandom());
            wins = 5'($urandom());
            ovr = (k > 2) && (($urandom() % 6) == 0);
            orate = 8'($urandom());
            nl = fpra_limit_req_t'(54'({$urandom(), $urandom()}));
            if (k == 0) en = 6'h3F;
            if (k == 0) wins = 5'h1F;
            if (k == 1) en = 6'h20;
            if (k == 2) en = 6'h00;
            if (k < 2) nl.req = 6'h3F;
            wr(`FPRA_ADDR_CTRL, {16'h0000, orate, 5'h00, ovr, 2'b00});
            wr(`FPRA_ADDR_LIMITS, {19'h0_0000, wins, 2'b00, en});
            @(posedge ref_clk_i);
            lim <= nl;
            mod_rate <= 8'($urandom());
            wait_cyc(3);
            `FPRA_CHK(firing_rate_o, exp_rate(en, wins, lim, ovr, orate, mod_rate));
        end
        $display("test arbitration done");
        // Each limit engages alone; only the abnormal ones alert.
        @(posedge ref_clk_i);
        lim.req <= '0;
        wr(`FPRA_ADDR_LIMITS, 32'h0000_003F);
        wr(`FPRA_ADDR_ALERT, 32'h0000_000F);
        for (int i = 0; i < 6; i++) begin
            @(posedge ref_clk_i);
            lim.req <= 6'(6'h01 << i);
            cnt = 0;
            repeat (6) begin
                wait_cyc(1);
                if (alert_o === 1'b1) cnt++;
            end
            `FPRA_CHK(cnt, ABN[i]);
            rd(`FPRA_ADDR_ALERT, {28'h000_0000, i == 5, i == 3, i == 1, i == 0});
            wr(`FPRA_ADDR_ALERT, 32'h0000_000F);
            @(posedge ref_clk_i);
            lim.req <= '0;
            wait_cyc(2);
        end
        $display("test alerts done");
        tally_and_finish();
    end

    // The whole sequence needs about 38000 cycles; a hang is cut off well past that.
    initial begin
        repeat (70000) @(posedge ref_clk_i);
        n_mismatch++;
        $display("watchdog expired at t=%0t", $time);
        tally_and_finish();
    end
endmodule

`default_nettype wire
